// >>> verilog/cct_timer.sv
`timescale 1ns/100ps

// Functional notes
// - Three enables gate interrupts; reset clears them.
// - Control bits 4 to 2 read zero.
// - Edge select: 1 rising, 0 falling; reset-proof.
// - Compare match drives pin to level bit.
// - Capture flag clears: status read, capture low.
// - Compare flag clears: status read, compare low access.
// - Overflow flag clears: status read, count low.
// - Counter pair is read-only.
// - High read freezes low byte until low read.
// - Alternate pair latches, never clears overflow.
// - Capture edge copies counter; pair read-only.
// - Capture high read blocks captures until low.
// - Compare high write inhibits compares until low.
// - Stop freezes; reset exit restarts at FFFC.
// - Interrupt exit resumes; stop edge captured.
// - Wait keeps running; only the timer interrupt wakes.
// - Counter advances every four clocks.
// - Compare evaluated once per prescaler period.
module cct_timer
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wakeInterrupt,
  input wire logic capture_input_pin,
  output logic compare_output_pin,
  output logic timerIrq,
  output logic wakeRequest,
  output logic stopped
);

  cct_pkg::cct_access_t acc;
  cct_pkg::cct_control_t ctrl;
  cct_pkg::cct_control_t next_ctrl;
  cct_pkg::cct_power_t power;
  cct_pkg::cct_power_t next_power;
  logic capSync;
  logic capPrev;
  logic [15:0] counter;
  logic [15:0] next_counter;
  logic [1:0] prescale;
  logic [1:0] next_prescale;
  logic [7:0] countLowBuf;
  logic [7:0] next_countLowBuf;
  logic countLatched;
  logic next_countLatched;
  logic [7:0] altLowBuf;
  logic [7:0] next_altLowBuf;
  logic altLatched;
  logic next_altLatched;
  logic [15:0] capture;
  logic [15:0] next_capture;
  logic captureBlocked;
  logic next_captureBlocked;
  logic [15:0] compare;
  logic [15:0] next_compare;
  logic compareInhibit;
  logic next_compareInhibit;
  logic captureFlag;
  logic compareFlag;
  logic overflowFlag;
  logic next_captureFlag;
  logic next_compareFlag;
  logic next_overflowFlag;
  logic capArmed;
  logic cmpArmed;
  logic ovfArmed;
  logic next_capArmed;
  logic next_cmpArmed;
  logic next_ovfArmed;
  logic pendingEdge;
  logic next_pendingEdge;
  logic next_pin;
  logic next_capPrev;
  logic edgeSeen;
  logic tick;
  logic [7:0] rdByte;
  logic [31:0] next_prdata;
  logic waitDone;
  logic next_waitDone;

  // ==========================================================================
  // Bus front end and pin synchroniser.
  cct_apb_slave u_apb
  (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .clkEn(clkEn),
    .waitDone(waitDone),
    .pready(pready),
    .pslverr(pslverr),
    .access(acc)
  );

  cct_sync u_sync
  (
    .coreClk(core_clk),
    .clkEn(clkEn),
    .pinIn(capture_input_pin),
    .pinSync(capSync)
  );

  function automatic logic isRead(cct_pkg::cct_access_t a, logic [7:0] addr);
    isRead = a.rdEn && (a.addr == addr);
  endfunction

  function automatic logic isWrite(cct_pkg::cct_access_t a, logic [7:0] addr);
    isWrite = a.wrEn && (a.addr == addr);
  endfunction

  // ==========================================================================
  // Next-state logic.
  always_comb
  begin
    next_ctrl = ctrl;
    next_power = power;
    next_counter = counter;
    next_prescale = prescale;
    next_countLowBuf = countLowBuf;
    next_countLatched = countLatched;
    next_altLowBuf = altLowBuf;
    next_altLatched = altLatched;
    next_capture = capture;
    next_captureBlocked = captureBlocked;
    next_compare = compare;
    next_compareInhibit = compareInhibit;
    next_captureFlag = captureFlag;
    next_compareFlag = compareFlag;
    next_overflowFlag = overflowFlag;
    next_capArmed = capArmed;
    next_cmpArmed = cmpArmed;
    next_ovfArmed = ovfArmed;
    next_pendingEdge = pendingEdge;
    next_pin = compare_output_pin;
    next_capPrev = capSync;
    next_waitDone = psel & penable & clkEn & ~waitDone;
    edgeSeen = ctrl.captureEdgeSelect ? (capSync & ~capPrev) : (~capSync & capPrev);
    tick = (power != cct_pkg::CCT_STOP);
    rdByte = cct_pkg::BYTE_ZERO;

    // Control register; bits 4 to 2 are not stored.
    if (isWrite(acc, cct_pkg::ADDR_CONTROL))
    begin
      next_ctrl.captureIrqEnable = acc.wdata[cct_pkg::BIT_CAPTURE_IE];
      next_ctrl.compareIrqEnable = acc.wdata[cct_pkg::BIT_COMPARE_IE];
      next_ctrl.overflowIrqEnable = acc.wdata[cct_pkg::BIT_OVERFLOW_IE];
      next_ctrl.captureEdgeSelect = acc.wdata[cct_pkg::BIT_EDGE_SELECT];
      next_ctrl.compareOutputLevel = acc.wdata[cct_pkg::BIT_OUTPUT_LEVEL];
    end

    // Power modes.
    case (power)
      cct_pkg::CCT_RUN:
      begin
        if (isWrite(acc, cct_pkg::ADDR_POWER) && acc.wdata[cct_pkg::BIT_STOP_REQ])
        begin
          next_power = cct_pkg::CCT_STOP;
        end
        else if (isWrite(acc, cct_pkg::ADDR_POWER) && acc.wdata[cct_pkg::BIT_WAIT_REQ])
        begin
          next_power = cct_pkg::CCT_WAIT;
        end
      end
      cct_pkg::CCT_WAIT:
      begin
        if (wakeRequest)
        begin
          next_power = cct_pkg::CCT_RUN;
        end
      end
      cct_pkg::CCT_STOP:
      begin
        if (edgeSeen)
        begin
          next_pendingEdge = 1'b1;
        end
        if (wakeInterrupt)
        begin
          next_power = cct_pkg::CCT_RUN;
        end
      end
      default:
      begin
        next_power = cct_pkg::CCT_RUN;
      end
    endcase

    // Register reads and their side effects.
    if (acc.rdEn)
    begin
      case (acc.addr)
        cct_pkg::ADDR_CONTROL:
        begin
          rdByte = {ctrl.captureIrqEnable, ctrl.compareIrqEnable, ctrl.overflowIrqEnable,
                    3'h0, ctrl.captureEdgeSelect, ctrl.compareOutputLevel};
        end
        cct_pkg::ADDR_STATUS:
        begin
          rdByte = {captureFlag, compareFlag, overflowFlag, 5'h00};
          next_capArmed = captureFlag;
          next_cmpArmed = compareFlag;
          next_ovfArmed = overflowFlag;
        end
        cct_pkg::ADDR_COUNT_HIGH:
        begin
          rdByte = counter[15:8];
          if (!countLatched)
          begin
            next_countLowBuf = counter[7:0];
          end
          next_countLatched = 1'b1;
        end
        cct_pkg::ADDR_COUNT_LOW:
        begin
          rdByte = countLatched ? countLowBuf : counter[7:0];
          next_countLatched = 1'b0;
          if (ovfArmed)
          begin
            next_overflowFlag = 1'b0;
            next_ovfArmed = 1'b0;
          end
        end
        cct_pkg::ADDR_ALT_COUNT_HIGH:
        begin
          rdByte = counter[15:8];
          if (!altLatched)
          begin
            next_altLowBuf = counter[7:0];
          end
          next_altLatched = 1'b1;
        end
        cct_pkg::ADDR_ALT_COUNT_LOW:
        begin
          rdByte = altLatched ? altLowBuf : counter[7:0];
          next_altLatched = 1'b0;
        end
        cct_pkg::ADDR_CAPTURE_HIGH:
        begin
          rdByte = capture[15:8];
          next_captureBlocked = 1'b1;
        end
        cct_pkg::ADDR_CAPTURE_LOW:
        begin
          rdByte = capture[7:0];
          next_captureBlocked = 1'b0;
          if (capArmed)
          begin
            next_captureFlag = 1'b0;
            next_capArmed = 1'b0;
          end
        end
        cct_pkg::ADDR_COMPARE_HIGH:
        begin
          rdByte = compare[15:8];
        end
        cct_pkg::ADDR_COMPARE_LOW:
        begin
          rdByte = compare[7:0];
        end
        cct_pkg::ADDR_POWER:
        begin
          rdByte = {6'h00, power == cct_pkg::CCT_WAIT, power == cct_pkg::CCT_STOP};
        end
        default:
        begin
          rdByte = cct_pkg::BYTE_ZERO;
        end
      endcase
    end

    if (isWrite(acc, cct_pkg::ADDR_COMPARE_HIGH))
    begin
      next_compare[15:8] = acc.wdata;
      next_compareInhibit = 1'b1;
    end
    if (isWrite(acc, cct_pkg::ADDR_COMPARE_LOW))
    begin
      next_compare[7:0] = acc.wdata;
      next_compareInhibit = 1'b0;
    end
    if ((isRead(acc, cct_pkg::ADDR_COMPARE_LOW) || isWrite(acc, cct_pkg::ADDR_COMPARE_LOW))
        && cmpArmed)
    begin
      next_compareFlag = 1'b0;
      next_cmpArmed = 1'b0;
    end
    // counter and capture writes ignored (no write path exists).

    // Flag sets come after the clears so that a set in the clearing cycle wins.
    // divide by four prescaler
    if (tick)
    begin
      next_prescale = prescale + 2'h1;
      if (prescale == cct_pkg::PRESCALE_LAST)
      begin
        next_counter = counter + 16'h0001;
        if (counter == cct_pkg::COUNT_ALL_ONES)
        begin
          next_overflowFlag = 1'b1;
        end
      end
      if (prescale == cct_pkg::PRESCALE_COMPARE && !compareInhibit && counter == compare)
      begin
        next_compareFlag = 1'b1;
        next_pin = ctrl.compareOutputLevel;
      end
    end

    if (!captureBlocked && ((tick && edgeSeen) || (power == cct_pkg::CCT_STOP && wakeInterrupt
        && (pendingEdge || edgeSeen))))
    begin
      next_capture = counter;
      next_captureFlag = 1'b1;
      next_pendingEdge = 1'b0;
    end

    next_prdata = acc.rdEn ? {24'h000000, rdByte} : prdata;

    if (srst)
    begin
      next_ctrl.captureIrqEnable = 1'b0;
      next_ctrl.compareIrqEnable = 1'b0;
      next_ctrl.overflowIrqEnable = 1'b0;
      next_ctrl.compareOutputLevel = 1'b0;
      next_power = cct_pkg::CCT_RUN;
      next_counter = cct_pkg::COUNT_RESET;
      next_prescale = 2'h0;
      next_countLatched = 1'b0;
      next_altLatched = 1'b0;
      next_captureBlocked = 1'b0;
      next_compareInhibit = 1'b0;
      next_capArmed = 1'b0;
      next_cmpArmed = 1'b0;
      next_ovfArmed = 1'b0;
      next_pendingEdge = 1'b0;
      next_pin = 1'b0;
      next_waitDone = 1'b0;
      next_prdata = cct_pkg::PRDATA_ZERO;
      next_captureFlag = captureFlag;
      next_compareFlag = compareFlag;
      next_overflowFlag = overflowFlag;
      next_capture = capture;
    end
  end

  assign timerIrq = (captureFlag & ctrl.captureIrqEnable) | (compareFlag & ctrl.compareIrqEnable)
                    | (overflowFlag & ctrl.overflowIrqEnable);
  assign wakeRequest = timerIrq;
  assign stopped = (power == cct_pkg::CCT_STOP);

  // ==========================================================================
  // State registers; clock enable low freezes everything but reset.
  always_ff @(posedge core_clk)
  begin
    if (clkEn || srst)
    begin
      ctrl <= next_ctrl;
      power <= next_power;
      counter <= next_counter;
      prescale <= next_prescale;
      countLowBuf <= next_countLowBuf;
      countLatched <= next_countLatched;
      altLowBuf <= next_altLowBuf;
      altLatched <= next_altLatched;
      capture <= next_capture;
      captureBlocked <= next_captureBlocked;
      compare <= next_compare;
      compareInhibit <= next_compareInhibit;
      captureFlag <= next_captureFlag;
      compareFlag <= next_compareFlag;
      overflowFlag <= next_overflowFlag;
      capArmed <= next_capArmed;
      cmpArmed <= next_cmpArmed;
      ovfArmed <= next_ovfArmed;
      pendingEdge <= next_pendingEdge;
      compare_output_pin <= next_pin;
      capPrev <= next_capPrev;
      prdata <= next_prdata;
      waitDone <= next_waitDone;
    end
  end

endmodule // cct_timer

// >>> verilog/cct_pkg.sv
package cct_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h0c;
  localparam logic [7:0] ADDR_ALT_COUNT_HIGH = 8'h10;
  localparam logic [7:0] ADDR_ALT_COUNT_LOW = 8'h14;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h18;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h1c;
  localparam logic [7:0] ADDR_COMPARE_HIGH = 8'h20;
  localparam logic [7:0] ADDR_COMPARE_LOW = 8'h24;
  localparam logic [7:0] ADDR_POWER = 8'h28;

  // ==========================================================================
  // Control, status and power bit positions.
  localparam int BIT_CAPTURE_IE = 7;
  localparam int BIT_COMPARE_IE = 6;
  localparam int BIT_OVERFLOW_IE = 5;
  localparam int BIT_EDGE_SELECT = 1;
  localparam int BIT_OUTPUT_LEVEL = 0;
  localparam int BIT_CAPTURE_FLAG = 7;
  localparam int BIT_COMPARE_FLAG = 6;
  localparam int BIT_OVERFLOW_FLAG = 5;
  localparam int BIT_STOP_REQ = 0;
  localparam int BIT_WAIT_REQ = 1;

  // ==========================================================================
  // Reset and timing values.
  localparam logic [15:0] COUNT_RESET = 16'hfffc;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] PRESCALE_COMPARE = 2'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] PRDATA_ZERO = 32'h00000000;

  // ==========================================================================
  // Power-state machine.
  typedef enum logic [1:0] {
    CCT_RUN = 2'b00,
    CCT_STOP = 2'b01,
    CCT_WAIT = 2'b11
  } cct_power_t;

  // Decoded register access for one APB cycle.
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cct_access_t;

  // Control register fields.
  typedef struct packed {
    logic captureIrqEnable;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic captureEdgeSelect;
    logic compareOutputLevel;
  } cct_control_t;

endpackage

// >>> verilog/cct_sync.sv
`timescale 1ns/100ps

// ============================================================================
// Two-stage synchroniser for one pin input.
module cct_sync
(
  input wire logic coreClk,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic pinSync
);

  logic stage1;
  logic next_stage1;
  logic next_pinSync;

  always_comb
  begin
    next_stage1 = clkEn ? pinIn : stage1;
    next_pinSync = clkEn ? stage1 : pinSync;
  end

  always_ff @(posedge coreClk)
  begin
    stage1 <= next_stage1;
    pinSync <= next_pinSync;
  end

endmodule // cct_sync

// >>> verilog/cct_apb_slave.sv
`timescale 1ns/100ps

// ============================================================================
// APB slave front end; one wait state so registered read data stands at ready.
module cct_apb_slave
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic clkEn,
  input wire logic waitDone,
  output logic pready,
  output logic pslverr,
  output cct_pkg::cct_access_t access
);

  always_comb
  begin
    pready = waitDone;
    pslverr = 1'b0;
    access.rdEn = psel & penable & ~pwrite & clkEn & ~waitDone;
    access.wrEn = psel & penable & pwrite & clkEn & waitDone;
    access.addr = paddr;
    access.wdata = pwdata[7:0];
  end

endmodule // cct_apb_slave

// >>> verification/cct_timer_checker.sv
`timescale 1ns/100ps

// ============================================================================
// Port checker for the capture compare timer.
module cct_timer_checker
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic wakeInterrupt,
  input wire logic compare_output_pin,
  input wire logic timerIrq,
  input wire logic wakeRequest,
  input wire logic stopped
);
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic known = 1'b0;
  logic next_known;
  logic take;
  assign take = psel && penable && clkEn && paddr == cct_pkg::ADDR_CONTROL;
  // Shadow of the control register as software should see it.
  always_comb
  begin
    next_ctrl = ctrl;
    next_known = known;
    if (srst)
      next_ctrl = ctrl & 8'h02;
    else if (take && pwrite)
    begin
      next_ctrl = pwdata[7:0] & 8'he3;
      next_known = 1'b1;
    end
  end
  always_ff @(posedge core_clk)
  begin
    ctrl <= next_ctrl;
    known <= next_known;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_wake_follows: assert property (wakeRequest == timerIrq)
    else $error("wake request differs from timer irq");
  chk_irq_cleared: assert property ($fell(srst) |-> !timerIrq)
    else $error("irq high after reset");
  chk_pin_cleared: assert property ($fell(srst) |-> !compare_output_pin)
    else $error("compare pin high after reset");
  chk_run_after: assert property ($fell(srst) |-> !stopped)
    else $error("stop mode kept through reset");
  chk_wake_exit: assert property (stopped && wakeInterrupt && clkEn |-> ##[1:3] !stopped)
    else $error("stop not left on interrupt");
  chk_unused_zero: assert property (take && !pwrite |=> prdata[4:2] == 3'h0)
    else $error("unused control bits not zero");
  chk_ctrl_readback: assert property (take && !pwrite && known |=> prdata[7:0] == ctrl)
    else $error("control readback wrong");
  chk_pin_level: assert property ($changed(compare_output_pin) && known |-> compare_output_pin == ctrl[0])
    else $error("compare pin differs from level bit");
  cov_stop: cover property ($rose(stopped));
  cov_pin: cover property ($rose(compare_output_pin));
  cov_irq: cover property ($rose(timerIrq));
endmodule // cct_timer_checker

// >>> verification/cct_pin_partner.sv
`timescale 1ns/100ps

// ============================================================================
// Capture signal source; each level is held well past the pulse width.
module cct_pin_partner
(
  input wire logic core_clk,
  output logic capture_input_pin
);
  initial capture_input_pin = 1'b0;
  task automatic drive(input logic lvl);
    @(posedge core_clk);
    capture_input_pin <= lvl;
    repeat (20) @(posedge core_clk);
  endtask
endmodule // cct_pin_partner

// >>> verification/tb.sv
`timescale 1ns/100ps

// ============================================================================
// Self-checking bench for the capture compare timer.
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic wakeInterrupt = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic capPin;
  logic cmpPin;
  logic timerIrq;
  logic wakeRequest;
  logic stopped;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] d;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] cap;
  always #4 core_clk = ~core_clk;
  cct_timer dut (.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .wakeInterrupt(wakeInterrupt), .capture_input_pin(capPin),
    .compare_output_pin(cmpPin), .timerIrq(timerIrq), .wakeRequest(wakeRequest),
    .stopped(stopped));
  cct_pin_partner src (.core_clk(core_clk), .capture_input_pin(capPin));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic near(input logic [15:0] v, input logic [15:0] r, input int lo,
    input int hi);
    logic [15:0] df;
    df = v - r;
    return df >= lo && df <= hi;
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'($urandom), wd};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      bad_count++;
      summarize();
    end
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    logic [7:0] x;
    apb(1'b1, ad, wd, x);
  endtask
  task automatic rd8(input logic [7:0] ad, output logic [7:0] v);
    apb(1'b0, ad, 8'h00, v);
  endtask
  task automatic rd16(input logic [7:0] ad, output logic [15:0] v);
    rd8(ad, v[15:8]);
    rd8(ad + 8'h04, v[7:0]);
  endtask
  task automatic waitFlag(input int bitn);
    for (int i = 0; i < 40; i++)
    begin
      rd8(cct_pkg::ADDR_STATUS, d);
      if (d[bitn] === 1'b1)
        return;
    end
    bad_count++;
    summarize();
  endtask
  initial
  begin
    void'($urandom(5113));
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      a[7:0] = $urandom;
      wr(cct_pkg::ADDR_CONTROL, a[7:0]);
      rd8(cct_pkg::ADDR_CONTROL, d);
      check("control", d, a[7:0] & 8'he3);
    end
    rd8(cct_pkg::ADDR_STATUS, d);
    check("overflow set", d[5], 1'b1);
    rd16(cct_pkg::ADDR_ALT_COUNT_HIGH, a);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("overflow kept", d[5], 1'b1);
    rd16(cct_pkg::ADDR_COUNT_HIGH, a);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("overflow clear", d[5], 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      wr(cct_pkg::ADDR_COUNT_HIGH + 8'(i * 8), 8'h00);
      rd8(cct_pkg::ADDR_COUNT_HIGH + 8'(i * 8), a[15:8]);
      repeat (64) @(posedge core_clk);
      rd8(cct_pkg::ADDR_COUNT_LOW + 8'(i * 8), a[7:0]);
      rd16(cct_pkg::ADDR_COUNT_HIGH + 8'(i * 8), b);
      check("count latch", near(b, a, 12, 24), 1'b1);
    end
    wr(cct_pkg::ADDR_CONTROL, 8'h02);
    src.drive(1'b1);
    waitFlag(7);
    rd16(cct_pkg::ADDR_CAPTURE_HIGH, cap);
    rd16(cct_pkg::ADDR_COUNT_HIGH, b);
    check("capture value", near(b, cap, 0, 24), 1'b1);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("capture clear", d[7], 1'b0);
    src.drive(1'b0);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("wrong edge", d[7], 1'b0);
    rd8(cct_pkg::ADDR_CAPTURE_HIGH, d);
    src.drive(1'b1);
    rd8(cct_pkg::ADDR_CAPTURE_LOW, d);
    rd16(cct_pkg::ADDR_CAPTURE_HIGH, b);
    check("capture blocked", b, cap);
    rd16(cct_pkg::ADDR_COUNT_HIGH, a);
    a = a + 16'h0006 + 16'($urandom % 8);
    wr(cct_pkg::ADDR_CONTROL, 8'h03);
    wr(cct_pkg::ADDR_COMPARE_HIGH, a[15:8]);
    rd8(cct_pkg::ADDR_STATUS, d);
    wr(cct_pkg::ADDR_COMPARE_LOW, a[7:0]);
    waitFlag(6);
    check("compare pin", cmpPin, 1'b1);
    wr(cct_pkg::ADDR_COMPARE_LOW, a[7:0]);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("compare clear", d[6], 1'b0);
    rd8(cct_pkg::ADDR_STATUS, d);
    rd8(cct_pkg::ADDR_CAPTURE_LOW, d);
    wr(cct_pkg::ADDR_POWER, 8'h01);
    rd16(cct_pkg::ADDR_COUNT_HIGH, a);
    src.drive(1'b0);
    src.drive(1'b1);
    rd16(cct_pkg::ADDR_COUNT_HIGH, b);
    check("stop frozen", b, a);
    @(posedge core_clk);
    wakeInterrupt <= 1'b1;
    @(posedge core_clk);
    wakeInterrupt <= 1'b0;
    waitFlag(7);
    rd16(cct_pkg::ADDR_CAPTURE_HIGH, cap);
    check("stop capture", cap, a);
    wr(cct_pkg::ADDR_POWER, 8'h01);
    src.drive(1'b0);
    src.drive(1'b1);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd16(cct_pkg::ADDR_COUNT_HIGH, b);
    check("reset restart", near(b, 16'hfffc, 0, 2), 1'b1);
    rd8(cct_pkg::ADDR_STATUS, d);
    check("reset no flag", d[7], 1'b0);
    rd16(cct_pkg::ADDR_CAPTURE_HIGH, b);
    check("reset capture", b, cap);
    wr(cct_pkg::ADDR_CONTROL, 8'h82);
    src.drive(1'b0);
    src.drive(1'b1);
    waitFlag(7);
    check("irq raised", timerIrq, 1'b1);
    wr(cct_pkg::ADDR_CONTROL, 8'h02);
    @(posedge core_clk);
    check("irq masked", timerIrq, 1'b0);
    rd16(cct_pkg::ADDR_COUNT_HIGH, a);
    clkEn <= 1'b0;
    repeat (8 + $urandom % 32) @(posedge core_clk);
    clkEn <= 1'b1;
    rd16(cct_pkg::ADDR_COUNT_HIGH, b);
    check("enable freeze", near(b, a, 0, 3), 1'b1);
    wr(cct_pkg::ADDR_POWER, 8'h02);
    rd16(cct_pkg::ADDR_COUNT_HIGH, a);
    repeat (40) @(posedge core_clk);
    rd16(cct_pkg::ADDR_COUNT_HIGH, b);
    check("wait runs", near(b, a, 8, 16), 1'b1);
    summarize();
  end
endmodule // tb

bind cct_timer cct_timer_checker chk (.core_clk(core_clk), .srst(srst), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .wakeInterrupt(wakeInterrupt), .compare_output_pin(compare_output_pin),
  .timerIrq(timerIrq), .wakeRequest(wakeRequest), .stopped(stopped));
